// [inc/asu_pkg.sv]
// Purpose: serial unit constants
// Assumes: one clock
// Notes:   offsets local
package asu_pkg;
    localparam int unsigned ASU_ADDR_W = 3;
    localparam int unsigned ASU_DATA_W = 8;
    localparam int unsigned ASU_LEN_W  = 4;
    localparam int unsigned ASU_DIV_W  = 16;

    // register offsets
    localparam logic [2:0] ASU_ADDR_STATUS_ONE    = 3'h4;
    localparam logic [2:0] ASU_ADDR_STATUS_TWO    = 3'h5;
    localparam logic [2:0] ASU_ADDR_CONTROL_THREE = 3'h6;
    localparam logic [2:0] ASU_ADDR_DATA_BUFFER   = 3'h7;

    // status one fields
    localparam int unsigned S1_TDRE = 7;
    localparam int unsigned S1_TC   = 6;
    localparam int unsigned S1_RX_BUFFER_FULL_FLAG = 5;
    localparam int unsigned S1_IDLE = 4;
    localparam int unsigned S1_OVR  = 3;
    localparam int unsigned S1_NF   = 2;
    localparam int unsigned S1_FE   = 1;
    localparam int unsigned S1_PF   = 0;

    // status two fields
    localparam int unsigned S2_LBK   = 7;
    localparam int unsigned S2_EDGE  = 6;
    localparam int unsigned S2_INPUT_POLARITY_INVERT = 4;
    localparam int unsigned S2_STANDBY_IDLE_REPORT = 3;
    localparam int unsigned S2_LONG_BREAK_SELECT = 2;
    localparam int unsigned S2_LINE_BREAK_DETECT_ENABLE = 1;
    localparam int unsigned S2_RAF   = 0;

    // control three fields
    localparam int unsigned C3_RX9   = 7;
    localparam int unsigned C3_TX9   = 6;
    localparam int unsigned C3_SINGLE_WIRE_OUT_DIRECTION = 5;
    localparam int unsigned C3_OUTPUT_POLARITY_INVERT = 4;
    localparam int unsigned C3_ERRIE_HI = 3;

    localparam logic [7:0] ASU_S2_WR_MASK = 8'h1e;
    localparam logic [7:0] ASU_C3_WR_MASK = 8'h7f;
    localparam logic [7:0] ASU_RESET_BYTE = 8'h00;
    localparam logic [5:0] ASU_S1_RESET   = 6'h00;

    // bit times, eight-bit; nine-bit adds one
    localparam logic [3:0] ASU_FRAME_BITS     = 4'ha;
    localparam logic [3:0] ASU_BRK_TX_SHORT   = 4'ha;
    localparam logic [3:0] ASU_BRK_TX_LONG    = 4'hd;
    localparam logic [3:0] ASU_BRK_DET_SHORT  = 4'ha;
    localparam logic [3:0] ASU_BRK_DET_LONG   = 4'hb;

    // bit time from the bus clock
    localparam int unsigned ASU_CLK_HZ       = 50_000_000;
    localparam int unsigned ASU_BAUD_DEFAULT = 9600;
    localparam int unsigned ASU_BIT_CYCLES   = ASU_CLK_HZ / ASU_BAUD_DEFAULT;

    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
        logic       frame_err;
        logic       noise;
        logic       parity_err;
    } asu_rx_char_s;

    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
    } asu_tx_word_s;
endpackage

// [hw/asu_break_gen.sv]
// Purpose: timed transmit break
// Assumes: i_bit_tick per bit time
// Notes:   starts on a tick; busy ignores
`timescale 1ns/10ps
module asu_break_gen
    import asu_pkg::*;
(
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_arst_n,
    input  wire logic                 i_bit_tick,
    input  wire logic                 i_break_req,
    input  wire logic [ASU_LEN_W-1:0] i_len,
    output logic                      o_active
);
    logic [ASU_LEN_W-1:0] cnt_q;
    logic                 active_q;
    logic                 pend_q;
    wire                  start   = pend_q & i_bit_tick & ~active_q;
    wire                  last    = active_q & i_bit_tick & (cnt_q == 4'h1);

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q    <= 4'h0;
            active_q <= 1'b0;
            pend_q   <= 1'b0;
        end else begin
            pend_q <= ~start & (pend_q | (i_break_req & ~active_q));
            if (start) begin
                cnt_q    <= i_len;
                active_q <= 1'b1;
            end else if (last) begin
                cnt_q    <= 4'h0;
                active_q <= 1'b0;
            end else if (active_q && i_bit_tick) begin
                cnt_q    <= cnt_q - 4'h1;
            end
        end
    end

    assign o_active = active_q;
endmodule

// [hw/asu_break_det.sv]
// Purpose: receive break detector
// Assumes: i_line synchronised
// Notes:   one pulse per low period
`timescale 1ns/10ps
module asu_break_det
    import asu_pkg::*;
(
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_arst_n,
    input  wire logic                 i_bit_tick,
    input  wire logic                 i_line,
    input  wire logic [ASU_LEN_W-1:0] i_thresh,
    output logic                      o_detect
);
    logic [ASU_LEN_W-1:0] cnt_q;
    logic                 done_q;
    logic                 det_q;
    wire                  hit = i_bit_tick & ~i_line & ~done_q
                                & (cnt_q + 4'h1 >= i_thresh);

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q  <= 4'h0;
            done_q <= 1'b0;
            det_q  <= 1'b0;
        end else begin
            det_q <= hit;
            if (i_line) begin
                cnt_q  <= 4'h0;
                done_q <= 1'b0;
            end else if (hit) begin
                done_q <= 1'b1;
            end else if (i_bit_tick && !done_q) begin
                cnt_q  <= cnt_q + 4'h1;
            end
        end
    end

    assign o_detect = det_q;
endmodule

// [hw/asu_regs.sv]
// Purpose: status two, control three, data
// Assumes: shifters outside
// Notes:   pins pass two flops
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
// Behaviour
// [RQ1] enabled break detect sets break flag; one clears
// [RQ2] active input edge sets edge flag; one clears
// [RQ3] receive inversion flips all received elements
// [RQ4] standby idle sets idle flag only if report set
// [RQ5] sent break 10 or 13 bit times, plus one nine-bit
// [RQ6] framing check ignores long break select
// [RQ7] break threshold 10 or 11 bit times, plus one nine-bit
// [RQ8] detect enable blocks framing and buffer-full flags
// [RQ9] receiver active set by start bit, cleared by idle
// [RQ10] received ninth bit in control three
// [RQ11] stored transmit ninth bit loads with data write
// [RQ12] single-wire direction bit sets pin direction
// [RQ13] transmit inversion flips all sent elements
// [RQ14] enabled error flags request interrupt
// [RQ15] separate receive and transmit buffers, reset zero
// [RQ16] data accesses end flag clearing
// [RQ17] both directions share one rate source
// [RQ18] bit rate from bus clock
// [RQ19] frame 10 bit times, 11 in nine-bit
// [RQ20] status one read then data read clears flags
// [RQ21] status two bit 5 reads zero
// [RQ22] zero writes keep flags; set beats clear
module asu_regs
    import asu_pkg::*;
#(
    parameter int unsigned BIT_CYCLES = ASU_BIT_CYCLES
) (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_arst_n,
    input  wire logic [ASU_ADDR_W-1:0] i_addr,
    input  wire logic [ASU_DATA_W-1:0] i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [ASU_DATA_W-1:0] o_rdata,
    input  wire logic                  i_nine_bit_mode,
    input  wire logic                  i_internal_loop_select,
    input  wire logic                  i_rx_source_select,
    input  wire logic                  i_rx_standby_wakeup,
    input  wire logic                  i_tdre,
    input  wire logic                  i_tc,
    input  wire logic                  i_send_break,
    input  wire logic                  i_tx_shift_bit,
    input  wire logic                  i_rx_start_valid,
    input  wire logic                  i_rx_idle_det,
    input  wire logic                  i_rx_char_valid,
    input  wire asu_rx_char_s          i_rx_char,
    input  wire logic                  i_rxd,
    input  wire logic                  i_txd_pin,
    output logic                       o_txd,
    output logic                       o_txd_oe_n,
    output logic                       o_rx_line,
    output logic                       o_bit_tick,
    output logic      [ASU_LEN_W-1:0]  o_frame_bits,
    output logic                       o_tx_load,
    output asu_tx_word_s               o_tx_word,
    output logic                       o_break_active,
    output logic                       o_err_irq
);
    // register state
    logic [ASU_DATA_W-1:0] rdata_q;
    logic                  line_break_flag_q;
    logic                  input_edge_flag_q;
    logic                  receiver_active_flag_q;
    logic [ASU_DATA_W-1:0] s2_ctrl_q;
    logic [ASU_DATA_W-1:0] c3_ctrl_q;
    logic                  rx_ninth_bit_q;
    logic [ASU_DATA_W-1:0] rx_buf_q;
    logic [ASU_DATA_W-1:0] tx_buf_q;
    logic [5:0]            s1_flags_q;
    logic [5:0]            s1_armed_q;
    logic                  tx_load_q;
    asu_tx_word_s          tx_word_q;
    logic [ASU_DIV_W-1:0]  div_q;
    logic                  tick_q;
    logic                  rxd_meta_q;
    logic                  rxd_sync_q;
    logic                  txp_meta_q;
    logic                  txp_sync_q;
    logic                  rx_line_q;
    logic                  rx_line_prev_q;
    logic                  txd_q;
    logic                  oe_n_q;

    // address decode
    wire sel_s1   = (i_addr == ASU_ADDR_STATUS_ONE);
    wire sel_s2   = (i_addr == ASU_ADDR_STATUS_TWO);
    wire sel_c3   = (i_addr == ASU_ADDR_CONTROL_THREE);
    wire sel_data = (i_addr == ASU_ADDR_DATA_BUFFER);
    wire wr_s2    = i_wr & sel_s2;
    wire wr_c3    = i_wr & sel_c3;
    wire wr_data  = i_wr & sel_data;
    wire rd_s1    = i_rd & sel_s1;
    wire rd_data  = i_rd & sel_data;

    // control fields
    wire input_polarity_invert     = s2_ctrl_q[S2_INPUT_POLARITY_INVERT];
    wire standby_idle_report       = s2_ctrl_q[S2_STANDBY_IDLE_REPORT];
    wire long_break_select         = s2_ctrl_q[S2_LONG_BREAK_SELECT];
    wire line_break_detect_enable  = s2_ctrl_q[S2_LINE_BREAK_DETECT_ENABLE];
    wire tx_ninth_bit              = c3_ctrl_q[C3_TX9];
    wire single_wire_out_direction = c3_ctrl_q[C3_SINGLE_WIRE_OUT_DIRECTION];
    wire output_polarity_invert    = c3_ctrl_q[C3_OUTPUT_POLARITY_INVERT];
    wire [3:0] err_int_enable      = c3_ctrl_q[C3_ERRIE_HI:0];
    wire single_wire = i_internal_loop_select & i_rx_source_select;
    wire int_loop    = i_internal_loop_select & ~i_rx_source_select;
    wire [3:0] nine_add = {3'h0, i_nine_bit_mode};

    // composed read values
    wire [7:0] s1_rd = {i_tdre, i_tc, s1_flags_q};
    wire [7:0] s2_rd = {line_break_flag_q, input_edge_flag_q, 1'b0, // RQ21
                        s2_ctrl_q[S2_INPUT_POLARITY_INVERT:S2_LINE_BREAK_DETECT_ENABLE],
                        receiver_active_flag_q};
    wire [7:0] c3_rd = {rx_ninth_bit_q, c3_ctrl_q[C3_TX9:0]};
    wire [7:0] rd_mux = sel_s1   ? s1_rd    :
                        sel_s2   ? s2_rd    :
                        sel_c3   ? c3_rd    :
                        sel_data ? rx_buf_q : ASU_RESET_BYTE;

    // shared bit-rate divider from the bus clock
    wire div_wrap = (div_q == ASU_DIV_W'(BIT_CYCLES - 1)); // RQ18

    // receive line: pin source select then inversion
    wire line_src = single_wire ? txp_sync_q :
                    int_loop    ? txd_q      : rxd_sync_q;
    wire rx_line  = line_src ^ input_polarity_invert; // RQ3
    wire active_edge = rx_line_prev_q & ~rx_line_q; // RQ2

    // break lengths and detection
    wire [3:0] brk_tx_len = (long_break_select ? ASU_BRK_TX_LONG
                                               : ASU_BRK_TX_SHORT)
                            + nine_add; // RQ5
    wire [3:0] brk_det_len = (line_break_detect_enable ? ASU_BRK_DET_LONG
                                                       : ASU_BRK_DET_SHORT)
                             + nine_add; // RQ7
    wire brk_detect;
    wire brk_active;

    // receive character acceptance
    wire rx_buffer_full_flag_now   = s1_flags_q[S1_RX_BUFFER_FULL_FLAG];
    wire char_lost  = i_rx_char_valid & rx_buffer_full_flag_now;
    wire char_take  = i_rx_char_valid & ~rx_buffer_full_flag_now
                      & ~line_break_detect_enable; // RQ8
    wire idle_set   = i_rx_idle_det
                      & (~i_rx_standby_wakeup | standby_idle_report); // RQ4

    // status one set and clear vectors
    wire [5:0] s1_set;
    assign s1_set[S1_RX_BUFFER_FULL_FLAG] = char_take;
    assign s1_set[S1_IDLE] = idle_set;
    assign s1_set[S1_OVR]  = char_lost;
    assign s1_set[S1_NF]   = char_take & i_rx_char.noise;
    assign s1_set[S1_FE]   = char_take & i_rx_char.frame_err; // RQ6
    assign s1_set[S1_PF]   = char_take & i_rx_char.parity_err;
    wire [5:0] s1_clr = rd_data ? s1_armed_q : 6'h00; // RQ16
    wire [5:0] s1_flags_d = (s1_flags_q & ~s1_clr) | s1_set; // RQ20

    // write-one-to-clear flags, set wins; receiver active flag set by start bit, cleared by idle
    wire lbk_set  = brk_detect & line_break_detect_enable; // RQ1
    wire lbk_clr  = wr_s2 & i_wdata[S2_LBK];
    wire edge_clr = wr_s2 & i_wdata[S2_EDGE];
    wire lbk_d    = lbk_set | (line_break_flag_q & ~lbk_clr); // RQ22
    wire edge_d   = active_edge | (input_edge_flag_q & ~edge_clr); // RQ22
    wire raf_d    = i_rx_start_valid
                    | (receiver_active_flag_q & ~i_rx_idle_det); // RQ9

    // transmit line and pin direction
    wire txd_d  = (i_tx_shift_bit & ~brk_active)
                  ^ output_polarity_invert; // RQ13
    wire oe_n_d = single_wire & ~single_wire_out_direction; // RQ12

    // register port
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_q <= ASU_RESET_BYTE;
        end else begin
            rdata_q <= i_rd ? rd_mux : ASU_RESET_BYTE;
        end
    end

    // status two and control three
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s2_ctrl_q              <= ASU_RESET_BYTE;
            c3_ctrl_q              <= ASU_RESET_BYTE;
            line_break_flag_q      <= 1'b0;
            input_edge_flag_q      <= 1'b0;
            receiver_active_flag_q <= 1'b0;
        end else begin
            if (wr_s2) begin
                s2_ctrl_q <= i_wdata & ASU_S2_WR_MASK; // RQ21
            end
            if (wr_c3) begin
                c3_ctrl_q <= i_wdata & ASU_C3_WR_MASK;
            end
            line_break_flag_q      <= lbk_d;
            input_edge_flag_q      <= edge_d;
            receiver_active_flag_q <= raf_d;
        end
    end

    // receive buffer, ninth bit and status one flags
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rx_buf_q       <= ASU_RESET_BYTE;
            rx_ninth_bit_q <= 1'b0;
            s1_flags_q     <= ASU_S1_RESET;
            s1_armed_q     <= ASU_S1_RESET;
        end else begin
            if (char_take) begin
                rx_buf_q       <= i_rx_char.data; // RQ15
                rx_ninth_bit_q <= i_rx_char.ninth & i_nine_bit_mode; // RQ10
            end
            s1_flags_q <= s1_flags_d;
            if (rd_s1) begin
                s1_armed_q <= s1_flags_q; // RQ20
            end else if (rd_data) begin
                s1_armed_q <= ASU_S1_RESET;
            end
        end
    end

    // transmit buffer and hand-off to the shifter
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tx_buf_q  <= ASU_RESET_BYTE;
            tx_load_q <= 1'b0;
            tx_word_q <= '0;
        end else begin
            tx_load_q <= wr_data; // RQ16
            if (wr_data) begin
                tx_buf_q        <= i_wdata; // RQ15
                tx_word_q.data  <= i_wdata;
                tx_word_q.ninth <= tx_ninth_bit & i_nine_bit_mode; // RQ11
            end
        end
    end

    // bit-rate enable shared by both directions
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_wrap ? '0 : div_q + ASU_DIV_W'(1);
            tick_q <= div_wrap; // RQ17
        end
    end

    // pin synchronisers and line registers
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rxd_meta_q     <= 1'b1;
            rxd_sync_q     <= 1'b1;
            txp_meta_q     <= 1'b1;
            txp_sync_q     <= 1'b1;
            rx_line_q      <= 1'b1;
            rx_line_prev_q <= 1'b1;
            txd_q          <= 1'b1;
            oe_n_q         <= 1'b0;
        end else begin
            rxd_meta_q     <= i_rxd;
            rxd_sync_q     <= rxd_meta_q;
            txp_meta_q     <= i_txd_pin;
            txp_sync_q     <= txp_meta_q;
            rx_line_q      <= rx_line;
            rx_line_prev_q <= rx_line_q;
            txd_q          <= txd_d;
            oe_n_q         <= oe_n_d;
        end
    end

    asu_break_gen u_break_gen (
        .i_sys_clk   (i_sys_clk),
        .i_arst_n    (i_arst_n),
        .i_bit_tick  (tick_q),
        .i_break_req (i_send_break),
        .i_len       (brk_tx_len),
        .o_active    (brk_active)
    );

    asu_break_det u_break_det (
        .i_sys_clk   (i_sys_clk),
        .i_arst_n    (i_arst_n),
        .i_bit_tick  (tick_q),
        .i_line      (rx_line_q),
        .i_thresh    (brk_det_len),
        .o_detect    (brk_detect)
    );

    // outputs
    assign o_rdata        = rdata_q;
    assign o_txd          = txd_q;
    assign o_txd_oe_n     = oe_n_q;
    assign o_rx_line      = rx_line_q;
    assign o_bit_tick     = tick_q;
    assign o_frame_bits   = ASU_FRAME_BITS + nine_add; // RQ19
    assign o_tx_load      = tx_load_q;
    assign o_tx_word      = tx_word_q;
    assign o_break_active = brk_active;
    assign o_err_irq      = |({s1_flags_q[S1_OVR], s1_flags_q[S1_NF],
                               s1_flags_q[S1_FE], s1_flags_q[S1_PF]}
                              & err_int_enable); // RQ14
endmodule

// [test/asu_regs_props.sv]
// Purpose: port checks
// Assumes: one clock
// Notes:   bind at end
`timescale 1ns/10ps
module asu_regs_props
    import asu_pkg::*;
(
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_arst_n,
    input  wire logic [ASU_ADDR_W-1:0] i_addr,
    input  wire logic [ASU_DATA_W-1:0] i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    input  wire logic [ASU_DATA_W-1:0] o_rdata,
    input  wire logic                  i_nine_bit_mode,
    input  wire logic                  i_internal_loop_select,
    input  wire logic                  i_rx_source_select,
    input  wire logic                  o_txd_oe_n,
    input  wire logic                  o_bit_tick,
    input  wire logic [ASU_LEN_W-1:0]  o_frame_bits,
    input  wire logic                  o_tx_load,
    input  wire asu_tx_word_s          o_tx_word,
    input  wire logic                  o_break_active,
    input  wire logic                  o_err_irq
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    wire logic wr_data = i_wr && (i_addr == ASU_ADDR_DATA_BUFFER);
    wire logic one_wire = i_internal_loop_select && i_rx_source_select;

    a_rdata_zero:
        assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("stray read data");
    a_load_on_write:
        assert property (wr_data |=> o_tx_load)
        else $error("load missing");
    a_load_only_write:
        assert property (!wr_data |=> !o_tx_load)
        else $error("stray load");
    a_word_data:
        assert property (wr_data |=> o_tx_word.data == $past(i_wdata))
        else $error("word data wrong");
    a_ninth_eight:
        assert property (o_tx_load && !$past(i_nine_bit_mode)
            |-> !o_tx_word.ninth)
        else $error("ninth bit sent in eight-bit mode");
    a_frame_len:
        assert property (o_frame_bits == (i_nine_bit_mode ? 4'hb : 4'ha))
        else $error("frame length wrong");
    a_oe_drive:
        assert property (!one_wire |=> !o_txd_oe_n)
        else $error("pin released");
    a_tick_gap:
        assert property (o_bit_tick |=> !o_bit_tick [*3])
        else $error("bit ticks too close");
    a_break_hold:
        assert property ($rose(o_break_active) |-> o_break_active [*8])
        else $error("transmit break too short");

    c_load: cover property (o_tx_load);
    c_break: cover property ($rose(o_break_active));
    c_irq: cover property ($rose(o_err_irq));
endmodule

bind asu_regs asu_regs_props u_props (
    .i_sys_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_nine_bit_mode, .i_internal_loop_select, .i_rx_source_select,
    .o_txd_oe_n, .o_bit_tick, .o_frame_bits, .o_tx_load, .o_tx_word,
    .o_break_active, .o_err_irq
);

// [test/asu_node_model.sv]
// Purpose: remote node
// Assumes: line idles high
// Notes:   measures txd low time
`timescale 1ns/10ps
module asu_node_model #(
    parameter int BIT_CYCLES = 8
) (
    input  wire logic i_sys_clk,
    input  wire logic i_txd,
    output logic      o_rxd
);
    initial o_rxd = 1'h1;
    task automatic set_line(input logic v);
        @(posedge i_sys_clk);
        o_rxd <= v;
    endtask
    // low for nbits bit times
    task automatic hold_low(input int nbits);
        set_line(1'h0);
        repeat (nbits * BIT_CYCLES - 1) @(posedge i_sys_clk);
        o_rxd <= 1'h1;
    endtask
    task automatic measure(output int n);
        n = 0;
        while (i_txd !== 1'h0 && n < 4000) begin
            @(posedge i_sys_clk);
            n++;
        end
        n = 0;
        while (i_txd === 1'h0 && n < 4000) begin
            @(posedge i_sys_clk);
            n++;
        end
    endtask
endmodule

// [test/tb_async_serial_status2_ctrl3_data.sv]
// Purpose: register bench
// Assumes: short bit time
// Notes:   node model on line
`timescale 1ns/10ps
module tb_async_serial_status2_ctrl3_data
    import asu_pkg::*;
;
    localparam int BC = 8;
    localparam logic [2:0] S1 = ASU_ADDR_STATUS_ONE;
    localparam logic [2:0] S2 = ASU_ADDR_STATUS_TWO;
    localparam logic [2:0] C3 = ASU_ADDR_CONTROL_THREE;
    localparam logic [2:0] DB = ASU_ADDR_DATA_BUFFER;
    logic         clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0;
    logic [2:0]   addr = 3'h0;
    logic [7:0]   wdata = 8'h00, rdata, rv;
    logic         nine = 1'h0, lp = 1'h0, src = 1'h0, stby = 1'h0;
    logic         brk = 1'h0, stv = 1'h0, idl = 1'h0, chv = 1'h0;
    asu_rx_char_s ch = '0;
    logic         rxd, txd, oe_n, rxl, tick, ld, bact, irq;
    logic [3:0]   fbits;
    asu_tx_word_s tw;
    int           error_cnt = 0, n_compared = 0, cyc = 0, n;
    wire logic    pin = oe_n ? 1'h1 : txd;

    asu_regs #(.BIT_CYCLES(BC)) u_dut (
        .i_sys_clk(clk), .i_arst_n(rst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_nine_bit_mode(nine), .i_internal_loop_select(lp),
        .i_rx_source_select(src), .i_rx_standby_wakeup(stby),
        .i_tdre(1'h1), .i_tc(1'h0), .i_send_break(brk),
        .i_tx_shift_bit(1'h1), .i_rx_start_valid(stv),
        .i_rx_idle_det(idl), .i_rx_char_valid(chv), .i_rx_char(ch),
        .i_rxd(rxd), .i_txd_pin(pin), .o_txd(txd), .o_txd_oe_n(oe_n),
        .o_rx_line(rxl), .o_bit_tick(tick), .o_frame_bits(fbits),
        .o_tx_load(ld), .o_tx_word(tw), .o_break_active(bact),
        .o_err_irq(irq));
    asu_node_model #(.BIT_CYCLES(BC)) u_node (
        .i_sys_clk(clk), .i_txd(txd), .o_rxd(rxd));

    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [8:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic expr(input string nm, input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 rv = rdata;
        chk(nm, {1'h0, rv}, {1'h0, e});
    endtask
    task automatic pulse(input int which);
        @(posedge clk);
        stv <= (which == 0);
        idl <= (which == 1);
        brk <= (which == 2);
        @(posedge clk);
        {stv, idl, brk} <= 3'h0;
    endtask
    task automatic rx_char(input asu_rx_char_s c);
        @(posedge clk);
        ch <= c;
        chv <= 1'h1;
        @(posedge clk);
        chv <= 1'h0;
    endtask

    task automatic t_reset;
        expr("s2_reset", S2, 8'h00);
        expr("c3_reset", C3, 8'h00);
        expr("rx_reset", DB, 8'h00);
        expr("unmapped", 3'h0, 8'h00);
        wreg(S2, 8'hef);
        expr("s2_mask", S2, 8'h0e);
        wreg(S2, 8'h00);
    endtask
    task automatic t_edge;
        u_node.set_line(1'h0);
        repeat (6) @(posedge clk);
        expr("edge_fall", S2, 8'h40);
        wreg(S2, 8'h00);
        expr("edge_keep", S2, 8'h40);
        wreg(S2, 8'h50);
        repeat (4) @(posedge clk);
        chk("rx_line_inv", {8'h00, rxl}, 9'h001);
        expr("edge_clr", S2, 8'h10);
        u_node.set_line(1'h1);
        repeat (6) @(posedge clk);
        expr("edge_inv", S2, 8'h50);
        wreg(S2, 8'h40);
        expr("edge_none", S2, 8'h00);
    endtask
    task automatic t_break;
        for (int m = 0; m < 2; m++) begin
            nine <= m[0];
            wreg(S2, 8'h02);
            u_node.hold_low(9 + m);
            expr("brk_short", S2, 8'h42);
            wreg(S2, 8'h42);
            u_node.hold_low(12 + m);
            expr("brk_det", S2, 8'hc2);
            wreg(S2, 8'hc2);
            expr("brk_clr", S2, 8'h02);
        end
        rx_char({1'h0, 8'h00, 3'h4});
        expr("drop_char", S1, 8'h80);
        wreg(S2, 8'h00);
    endtask
    task automatic t_err;
        logic [7:0] d;
        nine <= 1'h1;
        for (int k = 0; k < 4; k++) begin
            d = 8'h5a + k[7:0];
            wreg(C3, 8'h0f ^ (8'h01 << k));
            rx_char({1'h1, d, k == 1, k == 2, k == 0});
            if (k == 3) rx_char({1'h0, 8'hff, 3'h0});
            @(negedge clk);
            chk("irq_masked", {8'h00, irq}, 9'h000);
            wreg(C3, 8'h0f);
            @(negedge clk);
            chk("irq_on", {8'h00, irq}, 9'h001);
            expr("s1_flags", S1, 8'ha0 | (8'h01 << k));
            expr("rx_ninth", C3, 8'h8f);
            expr("rx_data", DB, d);
            expr("s1_clear", S1, 8'h80);
            chk("irq_off", {8'h00, irq}, 9'h000);
        end
    endtask
    task automatic t_raf;
        pulse(0);
        expr("raf_set", S2, 8'h01);
        stby <= 1'h1;
        pulse(1);
        expr("raf_clr", S2, 8'h00);
        expr("idle_hidden", S1, 8'h80);
        wreg(S2, 8'h08);
        pulse(1);
        expr("idle_report", S1, 8'h90);
        stby <= 1'h0;
    endtask
    task automatic t_tx;
        nine <= 1'h0;
        wreg(C3, 8'h40);
        wreg(DB, 8'h3c);
        @(negedge clk);
        chk("tx_word_eight", tw, 9'h03c);
        nine <= 1'h1;
        wreg(DB, 8'ha5);
        @(negedge clk);
        chk("tx_load", {8'h00, ld}, 9'h001);
        chk("tx_word", tw, 9'h1a5);
        wreg(DB, 8'h3c);
        @(negedge clk);
        chk("tx_word_kept", tw, 9'h13c);
        lp <= 1'h1;
        wreg(C3, 8'h10);
        repeat (3) @(posedge clk);
        chk("txd_inv", {8'h00, txd}, 9'h000);
        chk("loop_line", {8'h00, rxl}, 9'h000);
        lp <= 1'h0;
        wreg(C3, 8'h00);
        for (int j = 0; j < 4; j++) begin
            nine <= j[0];
            wreg(S2, j[1] ? 8'h04 : 8'h00);
            pulse(2);
            u_node.measure(n);
            n = n - (j[1] ? 13 : 10) * BC - j[0] * BC;
            chk("brk_len", {8'h00, n >= -2 && n <= 2}, 9'h001);
        end
        wreg(S2, 8'h00);
        lp <= 1'h1;
        src <= 1'h1;
        repeat (3) @(posedge clk);
        chk("oe_input", {8'h00, oe_n}, 9'h001);
        wreg(C3, 8'h20);
        repeat (2) @(posedge clk);
        chk("oe_output", {8'h00, oe_n}, 9'h000);
        lp <= 1'h0;
        src <= 1'h0;
    endtask

    task automatic summarize;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        t_reset();
        t_edge();
        t_break();
        t_err();
        t_raf();
        t_tx();
        summarize();
    end
endmodule
